// ---- hdl/lti_pkg.sv ----
package lti_pkg;

    // register pointer values
    localparam logic [4:0] ADDR_INT_CTRL = 5'h02;
    localparam logic [4:0] ADDR_LOW_LSB = 5'h03;
    localparam logic [4:0] ADDR_LOW_MSB = 5'h04;
    localparam logic [4:0] ADDR_HIGH_LSB = 5'h05;
    localparam logic [4:0] ADDR_HIGH_MSB = 5'h06;
    localparam logic [4:0] ADDR_ANALOG = 5'h07;

    // reset values
    localparam logic [7:0] RST_INT_CTRL = 8'h00;
    localparam logic [7:0] RST_LIMIT = 8'h00;
    localparam logic [7:0] RST_ANALOG = 8'h00;
    localparam logic [4:0] RST_PTR = 5'h00;

    // reserved bits read back as zero
    localparam logic [7:0] INT_CTRL_MASK = 8'h7f;
    localparam logic [7:0] ANALOG_MASK = 8'h03;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // interrupt control fields
    localparam int HALT_BIT = 6;
    localparam int MODE_HI = 5;
    localparam int MODE_LO = 4;
    localparam int PERSIST_HI = 3;
    localparam int PERSIST_LO = 0;

    // analog register fields
    localparam int GAIN_HI = 1;
    localparam int GAIN_LO = 0;

    // command byte fields
    localparam int CMD_BIT = 7;
    localparam int TXN_HI = 6;
    localparam int TXN_LO = 5;
    localparam int PTR_HI = 4;
    localparam int PTR_LO = 0;

    localparam logic [3:0] PERSIST_EVERY = 4'h0;
    localparam logic [3:0] PERSIST_MAX = 4'hf;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // bus address, arbitrary
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_LEVEL = 2'b01,
        MODE_RSVD = 2'b10,
        MODE_TEST = 2'b11
    } lti_mode_t;

    typedef enum logic [1:0] {
        TXN_BYTE = 2'b00,
        TXN_WORD = 2'b01,
        TXN_RSVD = 2'b10,
        TXN_SPECIAL = 2'b11
    } lti_txn_t;

    typedef enum logic [1:0] {
        GAIN_X1 = 2'b00,
        GAIN_X8 = 2'b01,
        GAIN_X16 = 2'b10,
        GAIN_X111 = 2'b11
    } lti_gain_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_WRITE = 3'b011,
        ST_WRITE_ACK = 3'b100,
        ST_READ = 3'b101,
        ST_READ_ACK = 3'b110
    } lti_state_t;

endpackage : lti_pkg

// ---- hdl/lti_sync.sv ----
`timescale 1ns/100ps

// two flop synchroniser for pin inputs
module lti_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            meta_ff <= '1;
            sync_ff <= '1;
        end
        else
        begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;

endmodule : lti_sync

// ---- hdl/lti_light_threshold_irq.sv ----
// How it works
// - interrupt pin is open drain, pulled low when asserted, released otherwise
// - level mode raises interrupt when last result leaves window, after persistence
// - interrupt holds until host sends command with transaction code 11
// - halt bit 6 set stops integration once interrupt is asserted
// - mode field 5:4: 00 off, 01 level, 10 reserved, 11 test (pin driven low)
// - persistence 0000 interrupts on every conversion regardless of thresholds
// - persistence 0001 interrupts on any single out-of-range result
// - persistence 2 to 15 needs that many consecutive out-of-range periods
// - only channel 0 result is compared, channel 1 ignored
// - result at or below low threshold is out of range
// - result above high threshold is out of range; equal is in range
// - thresholds are built from byte pairs at 3h/4h and 5h/6h
// - all four threshold bytes reset to zero
// - first data byte with top bit set is taken as command and pointer
// - gain field 1:0 selects 1x, 8x, 16x or 111x
// - interrupt control and gain registers reset to zero
// - single-byte data writes cannot carry values with top bit set
`timescale 1ns/100ps

module lti_light_threshold_irq #(
    parameter logic [6:0] DEV_ADDR = lti_pkg::DEV_ADDR_DEFAULT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic conv_done_i,
    input wire logic [15:0] ch0_result_i,
    output logic irq_n_o,
    output logic irq_n_oe,
    output logic halt_integration_o,
    output logic [1:0] gain_sel_o
);

    function automatic logic [15:0] pair16(input logic [7:0] msb, input logic [7:0] lsb);
        pair16 = {msb, lsb};
    endfunction : pair16

    logic [1:0] pins_sync;
    logic scl_s;
    logic sda_s;
    logic scl_d_ff;
    logic sda_d_ff;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    lti_pkg::lti_state_t state_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic rw_ff;
    logic first_ff;
    logic ack_oe_ff;
    logic master_ack_ff;

    logic [4:0] ptr_ff;
    lti_pkg::lti_txn_t txn_ff;
    logic [4:0] cmd_ptr;
    logic wr_byte_done;
    logic cmd_take;
    logic data_wr;
    logic rd_byte_end;
    logic irq_clr;
    logic [7:0] rd_data;

    logic [7:0] int_ctrl_ff;
    logic [7:0] low_lsb_ff;
    logic [7:0] low_msb_ff;
    logic [7:0] high_lsb_ff;
    logic [7:0] high_msb_ff;
    logic [7:0] analog_ff;

    logic [15:0] low_limit;
    logic [15:0] high_limit;
    logic [1:0] mode;
    logic [3:0] persist;
    logic halt_on_irq;
    logic below_low;
    logic above_high;
    logic out_of_range;
    logic [3:0] persist_cnt_ff;
    logic [3:0] nxt_persist_cnt;
    logic trigger;
    logic irq_set;
    logic irq_ff;

    // pin sampling and bus conditions
    lti_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .d({scl_i, sda_i}),
        .q(pins_sync)
    );

    assign scl_s = pins_sync[1];
    assign sda_s = pins_sync[0];

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end
        else
        begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d_ff;
    assign scl_fall = ~scl_s & scl_d_ff;
    assign start_seen = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign stop_seen = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    // bus byte engine
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_ff <= lti_pkg::ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            rw_ff <= 1'b0;
            first_ff <= 1'b0;
            ack_oe_ff <= 1'b0;
            master_ack_ff <= 1'b0;
        end
        else if (start_seen)
        begin
            state_ff <= lti_pkg::ST_ADDR;
            bit_cnt_ff <= 4'h0;
            ack_oe_ff <= 1'b0;
        end
        else if (stop_seen)
        begin
            state_ff <= lti_pkg::ST_IDLE;
            ack_oe_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                lti_pkg::ST_ADDR, lti_pkg::ST_WRITE:
                begin
                    if (scl_rise)
                    begin
                        shift_ff <= {shift_ff[6:0], sda_s};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_ff == lti_pkg::BITS_PER_BYTE)
                    begin
                        if (state_ff == lti_pkg::ST_WRITE)
                        begin
                            ack_oe_ff <= 1'b1;
                            state_ff <= lti_pkg::ST_WRITE_ACK;
                        end
                        else if (shift_ff[7:1] == DEV_ADDR)
                        begin
                            rw_ff <= shift_ff[0];
                            ack_oe_ff <= 1'b1;
                            state_ff <= lti_pkg::ST_ADDR_ACK;
                        end
                        else
                        begin
                            state_ff <= lti_pkg::ST_IDLE;
                        end
                    end
                end
                lti_pkg::ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        ack_oe_ff <= 1'b0;
                        bit_cnt_ff <= 4'h0;
                        if (rw_ff)
                        begin
                            shift_ff <= rd_data;
                            state_ff <= lti_pkg::ST_READ;
                        end
                        else
                        begin
                            first_ff <= 1'b1;
                            state_ff <= lti_pkg::ST_WRITE;
                        end
                    end
                end
                lti_pkg::ST_WRITE_ACK:
                begin
                    if (scl_fall)
                    begin
                        ack_oe_ff <= 1'b0;
                        bit_cnt_ff <= 4'h0;
                        first_ff <= 1'b0;
                        state_ff <= lti_pkg::ST_WRITE;
                    end
                end
                lti_pkg::ST_READ:
                begin
                    if (scl_rise)
                    begin
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (bit_cnt_ff == lti_pkg::BITS_PER_BYTE)
                        begin
                            state_ff <= lti_pkg::ST_READ_ACK;
                        end
                        else
                        begin
                            shift_ff <= {shift_ff[6:0], 1'b0};
                        end
                    end
                end
                lti_pkg::ST_READ_ACK:
                begin
                    if (scl_rise)
                    begin
                        master_ack_ff <= ~sda_s;
                    end
                    else if (scl_fall)
                    begin
                        bit_cnt_ff <= 4'h0;
                        if (master_ack_ff)
                        begin
                            shift_ff <= rd_data;
                            state_ff <= lti_pkg::ST_READ;
                        end
                        else
                        begin
                            state_ff <= lti_pkg::ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_ff <= lti_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // open drain data line, low while acking or sending a zero
    assign sda_o = 1'b0;
    assign sda_oe = ack_oe_ff | (state_ff == lti_pkg::ST_READ & ~shift_ff[7]);

    // first byte with top bit set is a command
    assign wr_byte_done = state_ff == lti_pkg::ST_WRITE && scl_fall && !start_seen
        && !stop_seen && bit_cnt_ff == lti_pkg::BITS_PER_BYTE;
    assign cmd_take = wr_byte_done & first_ff & shift_ff[lti_pkg::CMD_BIT];
    assign data_wr = wr_byte_done & ~cmd_take;
    assign rd_byte_end = state_ff == lti_pkg::ST_READ && scl_fall && !start_seen
        && !stop_seen && bit_cnt_ff == lti_pkg::BITS_PER_BYTE;
    assign cmd_ptr = shift_ff[lti_pkg::PTR_HI:lti_pkg::PTR_LO];
    assign irq_clr = cmd_take
        && shift_ff[lti_pkg::TXN_HI:lti_pkg::TXN_LO] == lti_pkg::TXN_SPECIAL;

    // register pointer and transaction type
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ptr_ff <= lti_pkg::RST_PTR;
            txn_ff <= lti_pkg::TXN_BYTE;
        end
        else if (cmd_take)
        begin
            ptr_ff <= cmd_ptr;
            txn_ff <= lti_pkg::lti_txn_t'(shift_ff[lti_pkg::TXN_HI:lti_pkg::TXN_LO]);
        end
        else if ((data_wr || rd_byte_end) && txn_ff == lti_pkg::TXN_WORD)
        begin
            ptr_ff <= ptr_ff + 5'h01;
        end
    end

    // register writes
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            int_ctrl_ff <= lti_pkg::RST_INT_CTRL;
            analog_ff <= lti_pkg::RST_ANALOG;
            low_lsb_ff <= lti_pkg::RST_LIMIT;
            low_msb_ff <= lti_pkg::RST_LIMIT;
            high_lsb_ff <= lti_pkg::RST_LIMIT;
            high_msb_ff <= lti_pkg::RST_LIMIT;
        end
        else if (data_wr)
        begin
            case (ptr_ff)
                lti_pkg::ADDR_INT_CTRL: int_ctrl_ff <= shift_ff & lti_pkg::INT_CTRL_MASK;
                lti_pkg::ADDR_LOW_LSB: low_lsb_ff <= shift_ff;
                lti_pkg::ADDR_LOW_MSB: low_msb_ff <= shift_ff;
                lti_pkg::ADDR_HIGH_LSB: high_lsb_ff <= shift_ff;
                lti_pkg::ADDR_HIGH_MSB: high_msb_ff <= shift_ff;
                lti_pkg::ADDR_ANALOG: analog_ff <= shift_ff & lti_pkg::ANALOG_MASK;
                default: ;
            endcase
        end
    end

    // register read mux
    always_comb
    begin
        case (ptr_ff)
            lti_pkg::ADDR_INT_CTRL: rd_data = int_ctrl_ff;
            lti_pkg::ADDR_LOW_LSB: rd_data = low_lsb_ff;
            lti_pkg::ADDR_LOW_MSB: rd_data = low_msb_ff;
            lti_pkg::ADDR_HIGH_LSB: rd_data = high_lsb_ff;
            lti_pkg::ADDR_HIGH_MSB: rd_data = high_msb_ff;
            lti_pkg::ADDR_ANALOG: rd_data = analog_ff;
            default: rd_data = lti_pkg::READ_UNMAPPED;
        endcase
    end

    assign low_limit = pair16(low_msb_ff, low_lsb_ff);
    assign high_limit = pair16(high_msb_ff, high_lsb_ff);

    assign mode = int_ctrl_ff[lti_pkg::MODE_HI:lti_pkg::MODE_LO];
    assign persist = int_ctrl_ff[lti_pkg::PERSIST_HI:lti_pkg::PERSIST_LO];
    assign halt_on_irq = int_ctrl_ff[lti_pkg::HALT_BIT];

    assign below_low = ch0_result_i <= low_limit;
    assign above_high = ch0_result_i > high_limit;
    assign out_of_range = below_low | above_high;

    assign nxt_persist_cnt = !out_of_range ? 4'h0 :
        (persist_cnt_ff == lti_pkg::PERSIST_MAX) ? lti_pkg::PERSIST_MAX :
        persist_cnt_ff + 4'h1;

    // every conversion, any single, n periods
    assign trigger = persist == lti_pkg::PERSIST_EVERY
        || (out_of_range && nxt_persist_cnt >= persist);

    // off and reserved codes raise nothing
    assign irq_set = conv_done_i & trigger & (mode == lti_pkg::MODE_LEVEL);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            persist_cnt_ff <= 4'h0;
        end
        else if (conv_done_i)
        begin
            persist_cnt_ff <= nxt_persist_cnt;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            irq_ff <= 1'b0;
        end
        else if (irq_set)
        begin
            irq_ff <= 1'b1;
        end
        else if (irq_clr)
        begin
            irq_ff <= 1'b0;
        end
    end

    // test code drives line for connectivity checks
    assign irq_n_o = 1'b0;
    assign irq_n_oe = (irq_ff && mode == lti_pkg::MODE_LEVEL) || mode == lti_pkg::MODE_TEST;

    assign halt_integration_o = halt_on_irq & irq_ff;

    assign gain_sel_o = analog_ff[lti_pkg::GAIN_HI:lti_pkg::GAIN_LO];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_level_raise;
        conv_done_i && out_of_range && persist == 4'h1 && mode == lti_pkg::MODE_LEVEL
            |=> irq_n_oe && !irq_n_o;
    endproperty
    a_level_raise: assert property (p_level_raise) else $error("level irq not raised");

    property p_clear;
        irq_clr && !irq_set |=> !irq_ff ##1 !irq_ff || $past(irq_set, 1);
    endproperty
    a_clear: assert property (p_clear) else $error("irq not cleared");

    property p_hold;
        irq_ff && !irq_clr |=> irq_ff;
    endproperty
    a_hold: assert property (p_hold) else $error("irq dropped without clear");

    property p_halt;
        halt_on_irq && $rose(irq_ff) |-> halt_integration_o throughout (!irq_clr)[*2];
    endproperty
    a_halt: assert property (p_halt) else $error("integration not halted");

    property p_mode_off;
        mode == lti_pkg::MODE_OFF |-> !irq_n_oe;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("disabled irq drives pin");

    property p_every;
        conv_done_i && persist == 4'h0 && mode == lti_pkg::MODE_LEVEL |=> irq_ff;
    endproperty
    a_every: assert property (p_every) else $error("persist 0 did not interrupt");

    property p_high_equal;
        conv_done_i && ch0_result_i == high_limit && ch0_result_i > low_limit && !irq_ff
            && persist != 4'h0 && !irq_clr |=> !irq_ff;
    endproperty
    a_high_equal: assert property (p_high_equal) else $error("equal high counted");

    property p_persist_clear;
        conv_done_i && !out_of_range |=> persist_cnt_ff == 4'h0;
    endproperty
    a_persist_clear: assert property (p_persist_clear) else $error("count not cleared");

    property p_persist_wait;
        conv_done_i && out_of_range && persist_cnt_ff == 4'h0 && persist == 4'h3 && !irq_ff
            && !irq_clr |=> !irq_ff;
    endproperty
    a_persist_wait: assert property (p_persist_wait) else $error("persist too early");

    property p_cmd_ptr;
        cmd_take |=> ptr_ff == $past(cmd_ptr) && $stable(int_ctrl_ff);
    endproperty
    a_cmd_ptr: assert property (p_cmd_ptr) else $error("command not stored");

endmodule : lti_light_threshold_irq

// ---- dv/lti_host.sv ----
`timescale 1ns/100ps

// bus host model: open-drain data, clock released high between frames
module lti_host #(
    parameter logic [6:0] ADDR = lti_pkg::DEV_ADDR_DEFAULT
) (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    int nack_cnt = 0;

    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // one bit: data set while clock low, sampled mid high phase
    task automatic clk_bit(input logic b, output logic s);
        tick(1);
        sda_pull <= ~b;
        tick(3);
        scl <= 1'b1;
        tick(2);
        s = sda_line;
        tick(2);
        scl <= 1'b0;
    endtask : clk_bit

    task automatic start;
        tick(1);
        sda_pull <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(3);
        sda_pull <= 1'b1;
        tick(3);
        scl <= 1'b0;
    endtask : start

    task automatic stop;
        tick(1);
        sda_pull <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(3);
        sda_pull <= 1'b0;
        tick(3);
    endtask : stop

    task automatic send(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(b[i], s);
        clk_bit(1'b1, s);
        if (s !== 1'b0)
            nack_cnt++;
    endtask : send

    // word cmd byte keeps pairs in one frame
    task automatic write_frame(input logic [7:0] b0, input logic [7:0] b1,
                               input logic [7:0] b2, input int n);
        start();
        send({ADDR, 1'b0});
        send(b0);
        if (n > 1)
            send(b1);
        if (n > 2)
            send(b2);
        stop();
    endtask : write_frame

    task automatic clear_irq;
        write_frame(8'he0, 8'h00, 8'h00, 1);
    endtask : clear_irq

    task automatic read_reg(input logic [4:0] ptr, output logic [7:0] d);
        logic s;
        start();
        send({ADDR, 1'b0});
        send(8'h80 | {3'h0, ptr});
        start();
        send({ADDR, 1'b1});
        for (int i = 7; i >= 0; i--)
        begin
            clk_bit(1'b1, s);
            d[i] = s;
        end
        clk_bit(1'b1, s);
        stop();
    endtask : read_reg

    task automatic probe(input logic [6:0] a);
        start();
        send({a, 1'b0});
        stop();
    endtask : probe

endmodule : lti_host

// ---- dv/lti_light_threshold_irq_test.sv ----
`timescale 1ns/100ps

module lti_light_threshold_irq_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic conv_done = 1'b0;
    logic [15:0] ch0 = 16'h0000;
    logic scl;
    logic sda_pull;
    logic sda_line;
    logic sda_o;
    logic sda_oe;
    logic irq_n_o;
    logic irq_n_oe;
    logic halt;
    logic [1:0] gain;
    logic [7:0] rd;
    logic [15:0] lo = 16'h0000;
    logic [15:0] hi = 16'h0000;
    logic [15:0] r;
    logic [3:0] p = 4'h0;
    logic [1:0] mode = 2'b00;
    logic hb = 1'b0;
    logic flag = 1'b0;
    int cnt = 0;
    int sel;
    int error_cnt = 0;
    int total_checks = 0;

    always #50 clk = ~clk;
    assign sda_line = ~(sda_pull | sda_oe);

    lti_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

    lti_light_threshold_irq dut (
        .clk(clk), .reset(reset), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe(sda_oe), .conv_done_i(conv_done), .ch0_result_i(ch0),
        .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .halt_integration_o(halt),
        .gain_sel_o(gain)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [4:0] ptr, input logic [7:0] v);
        host.write_frame(8'h80 | {3'h0, ptr}, v, 8'h00, 2);
    endtask : wr

    // expected flag from window, persistence count and mode
    task automatic conv(input logic [15:0] v);
        logic oor;
        oor = (v <= lo) || (v > hi);
        cnt = oor ? ((cnt < 15) ? cnt + 1 : 15) : 0;
        if (mode == 2'b01 && (p == 4'h0 || (oor && cnt >= int'(p))))
            flag = 1'b1;
        @(posedge clk);
        conv_done <= 1'b1;
        ch0 <= v;
        @(posedge clk);
        conv_done <= 1'b0;
        @(negedge clk);
        check(irq_n_oe, flag || mode == 2'b11);
        check(halt, hb & flag);
    endtask : conv

    task automatic clr;
        host.clear_irq();
        flag = 1'b0;
        @(negedge clk);
        check(irq_n_oe, mode == 2'b11);
    endtask : clr

    initial
    begin
        repeat (100000) @(posedge clk);
        check(1'b1, 1'b0);
        tally_and_finish();
    end

    initial
    begin
        void'($urandom(32'h0322));
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        for (int a = 2; a <= 8; a++)
        begin
            host.read_reg(a[4:0], rd);
            check(rd, 8'h00);
        end
        check(gain, 2'b00);
        check(irq_n_oe, 1'b0);
        host.read_reg(5'h10, rd);
        check(rd, 8'h00);
        host.probe(lti_pkg::DEV_ADDR_DEFAULT ^ 7'h01);
        mode = 2'b11;
        hb = 1'b1;
        p = 4'hf;
        wr(lti_pkg::ADDR_INT_CTRL, 8'h7f);
        host.read_reg(lti_pkg::ADDR_INT_CTRL, rd);
        check(rd, 8'h7f);
        check(irq_n_oe, 1'b1);
        for (int g = 0; g < 4; g++)
        begin
            wr(lti_pkg::ADDR_ANALOG, {6'h00, g[1:0]});
            host.read_reg(lti_pkg::ADDR_ANALOG, rd);
            check(rd, {6'h00, g[1:0]});
            check(gain, g[1:0]);
        end
        mode = 2'b01;
        for (int g = 0; g < 10; g++)
        begin
            lo = 16'($urandom_range(16'h0100, 16'h7fff));
            hi = lo + 16'($urandom_range(1, 16'h0800));
            p = (g < 2) ? g[3:0] : ((g == 2) ? 4'hf : 4'($urandom_range(2, 6)));
            hb = 1'($urandom_range(0, 1));
            host.write_frame(8'ha3, lo[7:0], lo[15:8], 3);
            host.write_frame(8'ha5, hi[7:0], hi[15:8], 3);
            host.read_reg(lti_pkg::ADDR_LOW_MSB, rd);
            check(rd, lo[15:8]);
            host.read_reg(lti_pkg::ADDR_HIGH_LSB, rd);
            check(rd, hi[7:0]);
            wr(lti_pkg::ADDR_INT_CTRL, {1'b0, hb, mode, p});
            conv(lo + 16'h0001);
            clr();
            for (int k = 0; k < 24; k++)
            begin
                sel = (g == 2) ? 0 : $urandom_range(0, 5);
                case (sel)
                    0: r = lo;
                    1: r = lo - 16'h0001;
                    2: r = hi;
                    3: r = hi + 16'h0001;
                    4: r = lo + 16'h0001;
                    default: r = 16'($urandom);
                endcase
                conv(r);
            end
        end
        host.read_reg(lti_pkg::ADDR_LOW_LSB, rd);
        check(rd, lo[7:0]);
        // single byte writes go to the gain register, thresholds stay word written
        host.write_frame(8'h87, 8'h00, 8'h00, 1);
        host.write_frame(8'h01, 8'h00, 8'h00, 1);
        host.read_reg(lti_pkg::ADDR_ANALOG, rd);
        check(rd, 8'h01);
        host.write_frame(8'h82, 8'h00, 8'h00, 1);
        host.read_reg(lti_pkg::ADDR_ANALOG, rd);
        check(rd, 8'h01);
        check(gain, 2'b01);
        p = 4'h1;
        hb = 1'b1;
        for (int m = 0; m < 4; m++)
        begin
            mode = m[1:0];
            wr(lti_pkg::ADDR_INT_CTRL, {1'b0, hb, mode, p});
            clr();
            conv(lo);
        end
        check(irq_n_o, 1'b0);
        check(sda_o, 1'b0);
        check(host.nack_cnt, 1);
        tally_and_finish();
    end

endmodule : lti_light_threshold_irq_test
